/* File: core/acp_cfg.svh */
// constants for the address/command parity checker
// assumes: included by the package and both ends, one clock at 20 MHz
`ifndef ACP_CFG_SVH
`define ACP_CFG_SVH
`define ACP_CLK_PERIOD_NS 50
`define ACP_DATA_WIDTH    21
`define ACP_HOLD_CYCLES   2'h2
`define ACP_ON_TIME_NS    10
`define ACP_OFF_TIME_NS   15
`endif

/* File: core/acp_pkg.sv */
// types shared by both ends of the parity checker link
// assumes: acp_cfg.svh is on the include path
`include "acp_cfg.svh"
package acp_pkg;
   typedef logic [`ACP_DATA_WIDTH-1:0] acp_data_t;
   typedef enum logic [1:0] {
      ACP_IDLE  = 2'b00,
      ACP_DELAY = 2'b01,
      ACP_HOLD1 = 2'b11,
      ACP_HOLD2 = 2'b10
   } acp_state_e;
endpackage

/* File: core/acp_link_if.sv */
// link between the memory controller end and the parity checker
// assumes: the open-drain error wire is resolved here from errOe
`timescale 1ns/1ps
interface acp_link_if
   import acp_pkg::*;
   ();
   acp_data_t dataIn;
   logic      parityBitIn;
   logic      chipSelectN0;
   logic      chipSelectN1;
   logic      selectGateEnable;
   logic      errOe;
   logic      errOut;
   logic      parityErrorN;
   // wire level: pulled high unless the checker sinks it
   assign parityErrorN = ~errOe;
   modport checker_end (
      input  dataIn,
      input  parityBitIn,
      input  chipSelectN0,
      input  chipSelectN1,
      input  selectGateEnable,
      output errOe,
      output errOut
   );
   modport controller_end (
      output dataIn,
      output parityBitIn,
      output chipSelectN0,
      output chipSelectN1,
      output selectGateEnable,
      input  parityErrorN
   );
endinterface

/* File: core/acp_parity_checker.sv */
// parity checker end: checks address/command word against the late parity bit
// assumes: link inputs come from another domain and are synchronised here
//
// Functional notes
// - odd count of D1..D21 plus parity flags error
// - parity bit checked against previous word
// - low error flag latched two cycles
// - new result evaluated only when flag high
// - controller holds inputs valid 10 ns after reset
// - controller holds inputs valid 15 ns after reset
// - no floating reset, gate enable, or inputs
// - error shown two cycles, one extra delay
// - reset clears registers, flag high
// - controller drives even parity across inputs
`timescale 1ns/1ps
`include "acp_cfg.svh"
module acp_parity_checker
   import acp_pkg::*;
   (
   input  wire logic mclk,
   input  wire logic reset_n,
   acp_link_if.checker_end link,
   output logic      parityErrorN
   );
   import acp_pkg::*;

   // ----------------------------------------
   // parity helpers
   // ----------------------------------------
   // odd when a word and its late parity bit hold an odd count of ones
   function automatic logic acp_odd_count(input acp_data_t w, input logic p);
      return ^{w, p};
   endfunction

   // a word is live when either active-low chip select is low
   function automatic logic acp_selected(input logic csN0, input logic csN1);
      return ~csN0 | ~csN1;
   endfunction

   // ----------------------------------------
   // receiver wake guard
   // ----------------------------------------
   // receivers settle within receiver_on_time after reset rises; a word caught in
   // that span is dropped, trading it away for no false flag on wake (one cycle at most)
   localparam int WAKE_CYCLES = (`ACP_ON_TIME_NS + `ACP_CLK_PERIOD_NS - 1) / `ACP_CLK_PERIOD_NS;
   logic [1:0] wakeCnt_r, wakeCnt_nxt;
   logic       receiverOnTime;

   always_comb begin
      wakeCnt_nxt = wakeCnt_r;
      if (wakeCnt_r != 2'(WAKE_CYCLES)) begin
         wakeCnt_nxt = wakeCnt_r + 2'h1;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wakeCnt_r <= 2'h0;
      end else begin
         wakeCnt_r <= wakeCnt_nxt;
      end
   end

   assign receiverOnTime = (wakeCnt_r == 2'(WAKE_CYCLES));

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   localparam int SYNC_W  = `ACP_DATA_WIDTH + 3;
   localparam int CS0_POS = `ACP_DATA_WIDTH;
   localparam int CS1_POS = `ACP_DATA_WIDTH + 1;
   localparam int PAR_POS = `ACP_DATA_WIDTH + 2;
   // chip selects wake up idle so the reset image of the lanes is never taken as a word
   localparam logic [SYNC_W-1:0] SYNC_RST = {1'h0, 2'h3, {`ACP_DATA_WIDTH{1'h0}}};
   logic [SYNC_W-1:0] syncA_r;
   logic [SYNC_W-1:0] syncB_r;
   acp_data_t                  dataS;
   logic                       parS;
   logic                       selectS;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         syncA_r <= SYNC_RST;
         syncB_r <= SYNC_RST;
      end else begin
         syncA_r <= {link.parityBitIn, link.chipSelectN1, link.chipSelectN0, link.dataIn};
         syncB_r <= syncA_r;
      end
   end
   assign dataS   = syncB_r[`ACP_DATA_WIDTH-1:0];
   assign selectS = receiverOnTime & acp_selected(syncB_r[CS0_POS], syncB_r[CS1_POS]);
   assign parS    = syncB_r[PAR_POS];

   // ----------------------------------------
   // word register and error sequencer
   // ----------------------------------------
   acp_data_t  word_r, word_nxt;
   logic       wordValid_r, wordValid_nxt;
   acp_state_e state_r, state_nxt;
   logic       errOe_r, errOe_nxt;
   logic       oddCount;

   // bit 0 of the word is D1; the partner parity arrives one cycle late
   assign oddCount = acp_odd_count(word_r, parS);

   always_comb begin
      word_nxt      = word_r;
      wordValid_nxt = 1'b0;
      state_nxt     = state_r;
      errOe_nxt     = 1'b0;
      if (selectS) begin
         word_nxt      = dataS;
         wordValid_nxt = 1'b1;
      end
      case (state_r)
         ACP_IDLE: begin
            // evaluating only with flag high keeps a held error stable
            if (wordValid_r && oddCount)
               state_nxt = ACP_DELAY;
         end
         ACP_DELAY: begin
            state_nxt = ACP_HOLD1;
            errOe_nxt = 1'b1;
         end
         ACP_HOLD1: begin
            state_nxt = ACP_HOLD2;
            errOe_nxt = 1'b1;
         end
         default: begin
            state_nxt = ACP_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         word_r      <= '0;
         wordValid_r <= 1'b0;
         state_r     <= ACP_IDLE;
         errOe_r     <= 1'b0;
      end else begin
         word_r      <= word_nxt;
         wordValid_r <= wordValid_nxt;
         state_r     <= state_nxt;
         errOe_r     <= errOe_nxt;
      end
   end

   assign link.errOe  = errOe_r;
   assign link.errOut = 1'b0;
   assign parityErrorN = ~errOe_r;
endmodule

/* File: core/acp_controller.sv */
// controller end: drives a word, then its even-parity bit one cycle later
// assumes: same mclk as the testbench; error wire is resolved in the interface
`timescale 1ns/1ps
`include "acp_cfg.svh"
module acp_controller
   import acp_pkg::*;
   (
   input  wire logic       mclk,
   input  wire logic       reset_n,
   acp_link_if.controller_end link,
   input  wire logic       issue,
   input  acp_pkg::acp_data_t wordIn,
   input  wire logic       badParity,
   input  wire logic [1:0] selectN,
   input  wire logic       gateEnable,
   output logic            errorSeen
   );
   import acp_pkg::*;

   // ----------------------------------------
   // drive side
   // ----------------------------------------
   acp_data_t data_r, data_nxt;
   logic      par_r, par_nxt;
   logic [1:0] sel_r, sel_nxt;
   logic      err_r, err_nxt;
   logic      ready_r, ready_nxt;
   logic [1:0] errS_r;

   always_comb begin
      data_nxt  = data_r;
      sel_nxt   = 2'b11;
      // parity is generated for the word sent last cycle
      par_nxt   = (^data_r) ^ badParity;
      ready_nxt = 1'b1;
      err_nxt   = ~errS_r[1];
      if (issue && ready_r) begin
         data_nxt = wordIn;
         sel_nxt  = selectN;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         data_r  <= '0;
         par_r   <= 1'b1;
         sel_r   <= 2'b11;
         err_r   <= 1'b0;
         ready_r <= 1'b0;
         errS_r  <= 2'b11;
      end else begin
         data_r  <= data_nxt;
         par_r   <= par_nxt;
         sel_r   <= sel_nxt;
         err_r   <= err_nxt;
         ready_r <= ready_nxt;
         errS_r  <= {errS_r[0], link.parityErrorN};
      end
   end

   // inputs never float: all driven from reset onward
   assign link.dataIn           = data_r;
   assign link.parityBitIn      = par_r;
   assign link.chipSelectN0     = sel_r[0];
   assign link.chipSelectN1     = sel_r[1];
   assign link.selectGateEnable = gateEnable;
   assign errorSeen             = err_r;
endmodule

/* File: tb/acp_link_props.sv */
// checker: error flag timing seen on the link
// assumes: link signals passed in by name
`timescale 1ns/1ps
module acp_link_props
   import acp_pkg::*;
   (
   input wire logic               mclk,
   input wire logic               reset_n,
   input wire acp_pkg::acp_data_t dataIn,
   input wire logic               parityBitIn,
   input wire logic               chipSelectN0,
   input wire logic               chipSelectN1,
   input wire logic               errOe
   );
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   wire logic sel = !(chipSelectN0 && chipSelectN1);
   // word at t-5 and its parity at t-4 decide the flag at t
   a_hold_two: assert property ($rose(errOe) |=> errOe ##1 !errOe) else $error("hold length");
   a_fell_late: assert property ($fell(errOe) |-> $past(errOe, 2)) else $error("fell early");
   a_err_gap: assert property ($fell(errOe) |=> !errOe) else $error("no gap");
   a_idle_quiet: assert property ($past(!sel, 5) |-> !$rose(errOe)) else $error("idle flagged");
   a_err_cause: assert property ($rose(errOe) |-> $past(sel, 5) &&
      ^{$past(dataIn, 5), $past(parityBitIn, 4)}) else $error("no cause");
   a_err_fires: assert property ($past(sel, 5) && ^{$past(dataIn, 5), $past(parityBitIn, 4)} &&
      !$past(errOe) && !$past(errOe, 2) && !$past(errOe, 3) && !$past(errOe, 4) |-> errOe) else $error("missed");
   a_reset_clear: assert property (disable iff (1'b0) !reset_n |-> !errOe) else $error("set in reset");
   a_wake_quiet: assert property ($rose(reset_n) |-> !errOe [*5]) else $error("set on wake");
endmodule

/* File: tb/tb.sv */
// bench: controller end drives checker end over one link
// assumes: core files compiled first
`timescale 1ns/1ps
`define CHK(n,e,s) begin tests_run++; if ((s)!==(e)) begin err_total++; $display("BAD %s exp %0h got %0h",n,e,s); end end
module tb;
   import acp_pkg::*;
   logic       mclk = 1'b0, reset_n = 1'b1, issue = 1'b0, bad = 1'b0;
   acp_data_t  word = 21'h0;
   logic [1:0] sel = 2'h3;
   logic       seenE, errN, seen;
   int         err_total = 0, tests_run = 0, hi;
   always #25 mclk = ~mclk;
   acp_link_if l ();
   acp_controller acp_controller_inst (.mclk, .reset_n, .link(l), .issue, .wordIn(word), .badParity(bad),
      .selectN(sel), .gateEnable(1'b1), .errorSeen(seenE));
   acp_parity_checker acp_parity_checker_inst (.mclk, .reset_n, .link(l), .parityErrorN(errN));
   acp_link_props acp_link_props_inst (.mclk, .reset_n, .dataIn(l.dataIn), .parityBitIn(l.parityBitIn),
      .chipSelectN0(l.chipSelectN0), .chipSelectN1(l.chipSelectN1), .errOe(l.errOe));
   // one word, then ten cycles of watching; cut drops reset mid-window
   task automatic run(acp_data_t w, logic p, logic [1:0] s, int cut);
      @(posedge mclk);
      issue <= 1'b1;
      word <= w;
      bad <= p;
      sel <= s;
      @(posedge mclk);
      issue <= 1'b0;
      hi = 0;
      seen = 1'b0;
      for (int i = 1; i <= 10; i++) begin
         @(posedge mclk);
         if (i == cut) reset_n <= 1'b0;
         #1;
         hi += l.errOe === 1'b1;
         seen |= seenE === 1'b1;
      end
   endtask
   task automatic t_quiet;
      for (int s = 0; s < 4; s++) begin
         run(21'h3 >> s, s == 3, 2'(s), 0);
         `CHK("quiet", 0, hi)
         `CHK("calm", 1'b0, seen)
      end
      $display("t_quiet done");
   endtask
   task automatic t_bad;
      run(21'h155555, 1'b1, 2'h2, 0);
      `CHK("held", 2, hi)
      `CHK("seen", 1'b1, seen)
      run(21'h155555, 1'b1, 2'h1, 6);
      `CHK("cut", 1, hi)
      `CHK("errN", 1'b1, errN)
      @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      $display("t_bad done");
   endtask
   task automatic close_out;
      $display("%0d checks, %0d mismatches", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      reset_n <= 1'b0;
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      t_quiet();
      t_bad();
      close_out();
   end
   // about 100 cycles expected, four times that allowed
   initial begin
      #20000;
      err_total++;
      close_out();
   end
endmodule
